// ==== src/tcc_pkg.sv ====
package tcc_pkg;
  // ****************************************
  // Register map (byte-wide registers, own offsets)
  // ****************************************
  localparam logic [3:0] ADDR_CAPTURE_HIGH = 4'h0;
  localparam logic [3:0] ADDR_CAPTURE_LOW  = 4'h1;
  localparam logic [3:0] ADDR_COMPARE_HIGH = 4'h2;
  localparam logic [3:0] ADDR_COMPARE_LOW  = 4'h3;
  localparam logic [3:0] ADDR_TIMER_CTRL   = 4'h4;
  localparam logic [3:0] ADDR_TIMER_STATUS = 4'h5;
  localparam logic [3:0] ADDR_ALT_HIGH     = 4'h6;
  localparam logic [3:0] ADDR_ALT_LOW      = 4'h7;
  localparam logic [3:0] ADDR_SRC_SEL      = 4'h8;

  // ****************************************
  // Control and status fields
  // ****************************************
  localparam int CTRL_COMPARE_OUTPUT_LEVEL_BIT = 0;
  localparam int CTRL_CAPTURE_EDGE_SELECT_BIT = 1;
  localparam int CTRL_TOIE_BIT = 5;
  localparam int CTRL_OCIE_BIT = 6;
  localparam int CTRL_ICIE_BIT = 7;
  localparam int STAT_TOF_BIT  = 5;
  localparam int STAT_OCF_BIT  = 6;
  localparam int STAT_ICF_BIT  = 7;
  localparam logic [7:0] CTRL_KEEP_MASK = 8'h02;

  // ****************************************
  // Counter and timing
  // ****************************************
  localparam logic [15:0] COUNT_PRESET = 16'hFFFC;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [1:0]  PRESCALE_LAST = 2'h3;
  localparam int          PRESCALE_DIV  = 4;
  localparam int          STARTUP_CYCLES = 4064;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
endpackage : tcc_pkg

// ==== src/tcc_tick_if.sv ====
`timescale 1ns/100ps
interface tcc_tick_if;
  logic        tick;
  logic [15:0] count;
  modport src (output tick, output count);
  modport dst (input tick, input count);
endinterface : tcc_tick_if

// ==== src/tcc_counter.sv ====
`timescale 1ns/100ps
module tcc_counter (
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  input  wire logic clk_en_in,
  tcc_tick_if.src   tick_if
);
  logic [1:0]  presc_ff;
  logic [15:0] count_ff;
  logic [12:0] start_ff;
  logic        running;

  // Start-up delay before counting
  assign running = (start_ff == 13'(tcc_pkg::STARTUP_CYCLES));

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      start_ff <= '0;
    end else if (clk_en_in && !running) begin
      start_ff <= start_ff + 13'h1;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      presc_ff <= '0;
    end else if (clk_en_in && running) begin
      presc_ff <= presc_ff + 2'h1;
    end
  end

  assign tick_if.tick = running && (presc_ff == tcc_pkg::PRESCALE_LAST);

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_ff <= tcc_pkg::COUNT_PRESET;
    end else if (clk_en_in && tick_if.tick) begin
      count_ff <= count_ff + 16'h1;
    end
  end

  assign tick_if.count = count_ff;

  count_preset_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (clk_en_in && !running) |=> $stable(count_ff))
    else $error("counter moved before start-up");
  count_step_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (clk_en_in && tick_if.tick) |=> count_ff == $past(count_ff) + 16'h1)
    else $error("counter did not step on tick");
endmodule : tcc_counter

// ==== src/tcc_edge_detect.sv ====
`timescale 1ns/100ps
module tcc_edge_detect (
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  input  wire logic clk_en_in,
  input  wire logic level_in,
  input  wire logic rising_in,
  output logic      edge_out
);
  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;

  // Two stages then edge compare; first stage read by second only
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff  <= 1'b0;
    end else if (clk_en_in) begin
      sync1_ff <= level_in;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  assign edge_out = rising_in ? (sync2_ff && !prev_ff) : (!sync2_ff && prev_ff);
endmodule : tcc_edge_detect

// ==== src/tcc_timer.sv ====
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// - Alternate counter reads never touch overflow flag, interrupts or counter.
// - Alternate counter bytes are read-only; writes ignored.
// - Reset presets counter to FFFC.
// - High-byte read freezes low byte until low byte read.
// - Counter advances through fixed divide-by-four prescaler.
// - After reset counter holds preset until start-up delay passes.
// - Two select bits pick pin, comparator flag or bus clock line.
// - Active edge copies counter into capture pair.
// - Edge polarity comes from the control edge-select bit.
// - Capture pair read-only and kept through reset.
// - Capture is equal to or one count above value before the transition.
// - Counter increments once every four clock cycles.
// - Capture high read blocks captures until capture low read.
// - Capture low read after status read clears capture flag.
// - Captures continue beside low reads; pair holds latest capture.
// - Every fourth cycle compare counter; on match drive level bit out.
// - Compare pair read/write and kept through reset.
// - Compare high write suspends compares until low write.
// - Compare low access after status read clears compare flag.
// - Level bit latched on match even if compare flag set.
// - Reset clears control register except edge-select bit.
// - Compare flag set when counter equals compare pair.
// - Level bit 1 drives output high, 0 drives it low.
// - Edge-select 1 means rising, 0 means falling.
// - Overflow flag set when counter rolls from FFFF to 0.
module tcc_timer (
  input  wire logic       mclk_in,
  input  wire logic       reset_n_in,
  input  wire logic       clk_en_in,
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       capture_input_in,
  input  wire logic       comparator_flag_in,
  input  wire logic       bus_clock_line_in,
  output logic            compare_output_out
);
  tcc_tick_if tick_if ();

  logic [7:0]  ctrl_ff;
  logic [1:0]  src_sel_ff;
  logic [15:0] capture_ff;
  logic [15:0] compare_ff;
  logic [7:0]  alt_low_ff;
  logic        alt_frozen_ff;
  logic        cap_block_ff;
  logic        cmp_block_ff;
  logic        capture_flag_ff;
  logic        compare_flag_ff;
  logic        overflow_flag_ff;
  logic        cap_armed_ff;
  logic        cmp_armed_ff;
  logic        cmp_out_ff;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;
  logic        edge_sel_ff;
  logic [7:0]  ctrl_view;
  logic        src_level;
  logic        cap_edge;
  logic        cap_take;
  logic        match;
  logic        rd_status;
  logic        rd_cap_low;
  logic        acc_cmp_low;
  logic        wr_ctrl;

  // ****************************************
  // Shared counter and capture edge
  // ****************************************
  tcc_counter u_counter (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .tick_if    (tick_if)
  );

  always_comb begin
    case (src_sel_ff)
      2'h0:    src_level = capture_input_in;
      2'h1:    src_level = comparator_flag_in;
      default: src_level = bus_clock_line_in;
    endcase
  end

  tcc_edge_detect u_edge (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .level_in   (src_level),
    .rising_in  (edge_sel_ff),
    .edge_out   (cap_edge)
  );

  // ****************************************
  // Access decode
  // ****************************************
  assign rd_status   = rd_in && (addr_in == tcc_pkg::ADDR_TIMER_STATUS);
  assign rd_cap_low  = rd_in && (addr_in == tcc_pkg::ADDR_CAPTURE_LOW);
  assign acc_cmp_low = (rd_in || wr_in) && (addr_in == tcc_pkg::ADDR_COMPARE_LOW);
  assign wr_ctrl     = wr_in && (addr_in == tcc_pkg::ADDR_TIMER_CTRL);

  // ****************************************
  // Control and source select
  // ****************************************
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_ff <= tcc_pkg::BYTE_ZERO;
    end else if (clk_en_in && wr_ctrl) begin
      ctrl_ff <= wdata_in & ~tcc_pkg::CTRL_KEEP_MASK;
    end
  end

  // Edge select has no reset: kept across reset
  always_ff @(posedge mclk_in) begin
    if (clk_en_in && wr_ctrl) begin
      edge_sel_ff <= wdata_in[tcc_pkg::CTRL_CAPTURE_EDGE_SELECT_BIT];
    end
  end

  // Kept bit lives in its own flop so each flop has one process
  assign ctrl_view = ctrl_ff | (tcc_pkg::CTRL_KEEP_MASK & {8{edge_sel_ff}});

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src_sel_ff <= '0;
    end else if (clk_en_in && wr_in && addr_in == tcc_pkg::ADDR_SRC_SEL) begin
      src_sel_ff <= wdata_in[1:0];
    end
  end

  // ****************************************
  // Input capture
  // ****************************************
  // Sync delays the edge, so the counter may already have stepped
  assign cap_take = cap_edge && !cap_block_ff;

  // Held value before the pending tick; taken after sync gives +0 or +1 count
  always_ff @(posedge mclk_in) begin
    if (clk_en_in && cap_take) begin
      capture_ff <= tick_if.count;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cap_block_ff <= 1'b0;
    end else if (clk_en_in) begin
      if (rd_in && addr_in == tcc_pkg::ADDR_CAPTURE_HIGH) begin
        cap_block_ff <= 1'b1;
      end else if (rd_cap_low) begin
        cap_block_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Output compare
  // ****************************************
  assign match = tick_if.tick && !cmp_block_ff && (tick_if.count == compare_ff);

  always_ff @(posedge mclk_in) begin
    if (clk_en_in && wr_in) begin
      if (addr_in == tcc_pkg::ADDR_COMPARE_HIGH) begin
        compare_ff[15:8] <= wdata_in;
      end
      if (addr_in == tcc_pkg::ADDR_COMPARE_LOW) begin
        compare_ff[7:0] <= wdata_in;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmp_block_ff <= 1'b0;
    end else if (clk_en_in && wr_in) begin
      if (addr_in == tcc_pkg::ADDR_COMPARE_HIGH) begin
        cmp_block_ff <= 1'b1;
      end else if (addr_in == tcc_pkg::ADDR_COMPARE_LOW) begin
        cmp_block_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmp_out_ff <= 1'b0;
    end else if (clk_en_in && match) begin
      cmp_out_ff <= ctrl_ff[tcc_pkg::CTRL_COMPARE_OUTPUT_LEVEL_BIT];
    end
  end

  assign compare_output_out = cmp_out_ff;

  // ****************************************
  // Flags: kept across reset, set wins over clear
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (clk_en_in) begin
      if (cap_take) begin
        capture_flag_ff <= 1'b1;
      end else if (rd_cap_low && cap_armed_ff) begin
        capture_flag_ff <= 1'b0;
      end
      if (match) begin
        compare_flag_ff <= 1'b1;
      end else if (acc_cmp_low && cmp_armed_ff) begin
        compare_flag_ff <= 1'b0;
      end
      // Alternate reads never clear this flag
      if (tick_if.tick && tick_if.count == tcc_pkg::COUNT_MAX) begin
        overflow_flag_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cap_armed_ff <= 1'b0;
      cmp_armed_ff <= 1'b0;
    end else if (clk_en_in) begin
      if (rd_status) begin
        cap_armed_ff <= capture_flag_ff;
        cmp_armed_ff <= compare_flag_ff;
      end else begin
        if (rd_cap_low) begin
          cap_armed_ff <= 1'b0;
        end
        if (acc_cmp_low) begin
          cmp_armed_ff <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Alternate counter low-byte latch
  // ****************************************
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      alt_frozen_ff <= 1'b0;
      alt_low_ff    <= tcc_pkg::BYTE_ZERO;
    end else if (clk_en_in && rd_in) begin
      if (addr_in == tcc_pkg::ADDR_ALT_HIGH && !alt_frozen_ff) begin
        alt_frozen_ff <= 1'b1;
        alt_low_ff    <= tick_if.count[7:0];
      end else if (addr_in == tcc_pkg::ADDR_ALT_LOW) begin
        alt_frozen_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read mux; writes to alternate bytes fall through
  // ****************************************
  always_comb begin
    nxt_rdata = tcc_pkg::BYTE_ZERO;
    case (addr_in)
      tcc_pkg::ADDR_CAPTURE_HIGH: nxt_rdata = capture_ff[15:8];
      tcc_pkg::ADDR_CAPTURE_LOW:  nxt_rdata = capture_ff[7:0];
      tcc_pkg::ADDR_COMPARE_HIGH: nxt_rdata = compare_ff[15:8];
      tcc_pkg::ADDR_COMPARE_LOW:  nxt_rdata = compare_ff[7:0];
      tcc_pkg::ADDR_TIMER_CTRL:   nxt_rdata = ctrl_view;
      tcc_pkg::ADDR_TIMER_STATUS: begin
        nxt_rdata[tcc_pkg::STAT_ICF_BIT] = capture_flag_ff;
        nxt_rdata[tcc_pkg::STAT_OCF_BIT] = compare_flag_ff;
        nxt_rdata[tcc_pkg::STAT_TOF_BIT] = overflow_flag_ff;
      end
      tcc_pkg::ADDR_ALT_HIGH:     nxt_rdata = tick_if.count[15:8];
      tcc_pkg::ADDR_ALT_LOW:
        nxt_rdata = alt_frozen_ff ? alt_low_ff : tick_if.count[7:0];
      tcc_pkg::ADDR_SRC_SEL:      nxt_rdata = {6'h00, src_sel_ff};
      default:                    nxt_rdata = tcc_pkg::BYTE_ZERO;
    endcase
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_ff <= tcc_pkg::BYTE_ZERO;
    end else if (clk_en_in && rd_in) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_out = rdata_ff;

  // ****************************************
  // Checks
  // ****************************************
  sequence cmp_high_wr_s;
    wr_in && addr_in == tcc_pkg::ADDR_COMPARE_HIGH;
  endsequence

  sequence alt_low_rd_s;
    clk_en_in && rd_in && addr_in == tcc_pkg::ADDR_ALT_LOW;
  endsequence

  compare_block_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (clk_en_in and cmp_high_wr_s) |=> !match)
    else $error("compare ran while suspended");
  capture_block_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    cap_block_ff |=> $stable(capture_ff))
    else $error("capture while blocked");
  capture_copy_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (clk_en_in && cap_take) |=> capture_ff == $past(tick_if.count))
    else $error("capture value wrong");
  compare_drive_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (clk_en_in && match) |=> compare_output_out == $past(ctrl_ff[tcc_pkg::CTRL_COMPARE_OUTPUT_LEVEL_BIT]))
    else $error("compare output level wrong");
  compare_flag_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (clk_en_in && match) |=> compare_flag_ff)
    else $error("compare flag not set");
  overflow_set_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (clk_en_in && tick_if.tick && tick_if.count == tcc_pkg::COUNT_MAX) |=> overflow_flag_ff)
    else $error("overflow flag not set");
  alt_freeze_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (alt_frozen_ff && !(rd_in && addr_in == tcc_pkg::ADDR_ALT_LOW)) |=> $stable(alt_low_ff))
    else $error("frozen low byte moved");
  overflow_keep_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (overflow_flag_ff && rd_in && addr_in == tcc_pkg::ADDR_ALT_LOW) |=> overflow_flag_ff)
    else $error("alternate read cleared overflow");
  alt_release_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    alt_low_rd_s |=> !alt_frozen_ff)
    else $error("low byte stayed frozen");
  capture_flag_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (clk_en_in && cap_take) |=> capture_flag_ff)
    else $error("capture flag not set");
  capture_clear_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (clk_en_in && rd_cap_low && cap_armed_ff && !cap_take) |=> !capture_flag_ff)
    else $error("capture flag not cleared");
  compare_clear_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (clk_en_in && acc_cmp_low && cmp_armed_ff && !match) |=> !compare_flag_ff)
    else $error("compare flag not cleared");
  pin_hold_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !(clk_en_in && match) |=> $stable(compare_output_out))
    else $error("compare pin moved without match");
  count_freeze_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !clk_en_in |=> $stable(tick_if.count))
    else $error("counter moved while frozen");
  source_pick_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (src_sel_ff == 2'h0) |-> (src_level == capture_input_in))
    else $error("capture source wrong");
endmodule : tcc_timer

// ==== bench/tcc_far_model.sv ====
`timescale 1ns/100ps
// ****************************************
// Far side: capture sources and compare pin
// ****************************************
module tcc_far_model (
  input  wire logic mclk_in,
  input  wire logic compare_output_in,
  output logic      capture_input_out,
  output logic      comparator_flag_out,
  output logic      bus_clock_line_out
);
  int   pin_changes = 0;
  logic pin_q       = 1'b0;

  // Serial clock line idles high under its pull-up
  initial begin
    capture_input_out   = 1'b0;
    comparator_flag_out = 1'b0;
    bus_clock_line_out  = 1'b1;
  end

  task automatic set_level(input int src, input logic lvl);
    @(posedge mclk_in);
    case (src)
      0: capture_input_out <= lvl;
      1: comparator_flag_out <= lvl;
      default: bus_clock_line_out <= lvl;
    endcase
  endtask

  // One rising and one falling edge per pulse, whatever the idle level
  task automatic pulse(input int src);
    logic idle;
    idle = (src > 1);
    set_level(src, !idle);
    repeat (12) @(posedge mclk_in);
    set_level(src, idle);
  endtask

  always @(posedge mclk_in) begin
    pin_q <= compare_output_in;
    if (pin_q !== compare_output_in) pin_changes <= pin_changes + 1;
  end
endmodule // tcc_far_model

// ==== bench/test_timer_capture_compare_16bit.sv ====
`timescale 1ns/100ps
module test_timer_capture_compare_16bit;
  logic        mclk_in    = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        clk_en_in  = 1'b1;
  logic [3:0]  addr_in    = 4'h0;
  logic [7:0]  wdata_in   = 8'h00;
  logic        wr_in      = 1'b0;
  logic        rd_in      = 1'b0;
  logic [7:0]  rdata_out;
  logic        cmp_pin;
  logic        cap_pin;
  logic        cmp_flag;
  logic        bus_line;
  int          n_fail     = 0;
  int          compares   = 0;
  int          n;
  logic [15:0] a;
  logic [15:0] b;
  logic [15:0] c;
  logic [7:0]  d;

  initial forever #2 mclk_in = ~mclk_in;

  tcc_timer dut_u (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .capture_input_in(cap_pin), .comparator_flag_in(cmp_flag),
    .bus_clock_line_in(bus_line), .compare_output_out(cmp_pin));

  tcc_far_model far_u (.mclk_in(mclk_in), .compare_output_in(cmp_pin),
    .capture_input_out(cap_pin), .comparator_flag_out(cmp_flag),
    .bus_clock_line_out(bus_line));

  // ****************************************
  // Bus access and checking
  // ****************************************
  task automatic wr_reg(input logic [3:0] ad, input logic [7:0] v);
    @(posedge mclk_in);
    addr_in  <= ad;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] ad, output logic [7:0] v);
    @(posedge mclk_in);
    addr_in <= ad;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in   <= 1'b0;
    @(posedge mclk_in);
    v = rdata_out;
  endtask

  // High byte first so the low byte comes from the same moment
  task automatic rd16(input logic [3:0] hi, output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd_reg(hi, h);
    rd_reg(hi + 4'h1, l);
    v = {h, l};
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] in_range(input logic [15:0] v, lo, hi);
    return {15'h0000, (v >= lo) && (v <= hi)};
  endfunction

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    rd16(tcc_pkg::ADDR_ALT_HIGH, a);
    chk(a, 16'hFFFC);
    repeat (3900) @(posedge mclk_in);
    rd16(tcc_pkg::ADDR_ALT_HIGH, a);
    chk(a, 16'hFFFC);
    repeat (300) @(posedge mclk_in);
    rd16(tcc_pkg::ADDR_ALT_HIGH, a);
    chk(in_range(a, 16'h0001, 16'h0040), 16'h0001);
    rd_reg(tcc_pkg::ADDR_TIMER_STATUS, d);
    chk({15'h0000, d[tcc_pkg::STAT_TOF_BIT]}, 16'h0001);
    // Live low reads exactly 40 cycles apart, writes in between
    rd_reg(tcc_pkg::ADDR_ALT_LOW, d);
    a[7:0] = d;
    wr_reg(tcc_pkg::ADDR_ALT_HIGH, 8'h00);
    wr_reg(tcc_pkg::ADDR_ALT_LOW, 8'h00);
    repeat (33) @(posedge mclk_in);
    rd_reg(tcc_pkg::ADDR_ALT_LOW, d);
    chk({8'h00, d - a[7:0]}, 16'h000A);
    // Enable low for 40 cycles: four enabled cycles between reads, one count
    rd_reg(tcc_pkg::ADDR_ALT_LOW, d);
    a[7:0] = d;
    @(posedge mclk_in);
    clk_en_in <= 1'b0;
    repeat (40) @(posedge mclk_in);
    clk_en_in <= 1'b1;
    rd_reg(tcc_pkg::ADDR_ALT_LOW, d);
    chk({8'h00, d - a[7:0]}, 16'h0001);
    // Low byte stays frozen across a second high read
    rd_reg(tcc_pkg::ADDR_ALT_HIGH, d);
    repeat (40) @(posedge mclk_in);
    rd_reg(tcc_pkg::ADDR_ALT_HIGH, d);
    rd_reg(tcc_pkg::ADDR_ALT_LOW, d);
    a[7:0] = d;
    rd_reg(tcc_pkg::ADDR_ALT_LOW, d);
    chk(in_range({8'h00, d - a[7:0]}, 16'h000B, 16'h000D), 16'h0001);
    rd_reg(tcc_pkg::ADDR_TIMER_STATUS, d);
    rd16(tcc_pkg::ADDR_ALT_HIGH, a);
    rd_reg(tcc_pkg::ADDR_TIMER_STATUS, d);
    chk({15'h0000, d[tcc_pkg::STAT_TOF_BIT]}, 16'h0001);
    // Every source selection, with a pulse on a source not selected
    wr_reg(tcc_pkg::ADDR_TIMER_CTRL, 8'h02);
    for (int s = 0; s < 4; s++) begin
      wr_reg(tcc_pkg::ADDR_SRC_SEL, s[7:0]);
      repeat (10) @(posedge mclk_in);
      rd16(tcc_pkg::ADDR_CAPTURE_HIGH, b);
      far_u.pulse(s == 0 ? 1 : 0);
      repeat (10) @(posedge mclk_in);
      rd16(tcc_pkg::ADDR_CAPTURE_HIGH, c);
      chk(c, b);
      rd16(tcc_pkg::ADDR_ALT_HIGH, a);
      far_u.pulse(s > 1 ? 2 : s);
      repeat (10) @(posedge mclk_in);
      rd16(tcc_pkg::ADDR_CAPTURE_HIGH, c);
      chk(in_range(c - a, 16'h0001, 16'h0006), 16'h0001);
    end
    wr_reg(tcc_pkg::ADDR_SRC_SEL, 8'h00);
    repeat (10) @(posedge mclk_in);
    rd16(tcc_pkg::ADDR_CAPTURE_HIGH, b);
    rd_reg(tcc_pkg::ADDR_CAPTURE_HIGH, d);
    far_u.pulse(0);
    repeat (10) @(posedge mclk_in);
    rd_reg(tcc_pkg::ADDR_CAPTURE_LOW, d);
    rd16(tcc_pkg::ADDR_CAPTURE_HIGH, c);
    chk(c, b);
    far_u.pulse(0);
    repeat (10) @(posedge mclk_in);
    rd_reg(tcc_pkg::ADDR_TIMER_STATUS, d);
    chk({15'h0000, d[tcc_pkg::STAT_ICF_BIT]}, 16'h0001);
    rd_reg(tcc_pkg::ADDR_CAPTURE_LOW, d);
    rd_reg(tcc_pkg::ADDR_TIMER_STATUS, d);
    chk({15'h0000, d[tcc_pkg::STAT_ICF_BIT]}, 16'h0000);
    // Falling edge selected: rise ignored, fall captured 40 cycles later
    wr_reg(tcc_pkg::ADDR_TIMER_CTRL, 8'h00);
    rd16(tcc_pkg::ADDR_ALT_HIGH, a);
    far_u.set_level(0, 1'b1);
    repeat (40) @(posedge mclk_in);
    far_u.set_level(0, 1'b0);
    repeat (10) @(posedge mclk_in);
    rd16(tcc_pkg::ADDR_CAPTURE_HIGH, c);
    chk(in_range(c - a, 16'h000B, 16'h000E), 16'h0001);
    // Compare: full update sequence, output level high
    wr_reg(tcc_pkg::ADDR_TIMER_CTRL, 8'h03);
    rd16(tcc_pkg::ADDR_ALT_HIGH, a);
    b = a + 16'h0018;
    wr_reg(tcc_pkg::ADDR_COMPARE_HIGH, b[15:8]);
    rd_reg(tcc_pkg::ADDR_TIMER_STATUS, d);
    wr_reg(tcc_pkg::ADDR_COMPARE_LOW, b[7:0]);
    chk({15'h0000, cmp_pin}, 16'h0000);
    repeat (120) @(posedge mclk_in);
    chk({15'h0000, cmp_pin}, 16'h0001);
    rd_reg(tcc_pkg::ADDR_TIMER_STATUS, d);
    chk({15'h0000, d[tcc_pkg::STAT_OCF_BIT]}, 16'h0001);
    // High byte alone would match 256 counts on, but must stay suspended
    wr_reg(tcc_pkg::ADDR_TIMER_CTRL, 8'h02);
    n = far_u.pin_changes;
    b = b + 16'h0100;
    wr_reg(tcc_pkg::ADDR_COMPARE_HIGH, b[15:8]);
    repeat (1100) @(posedge mclk_in);
    chk(far_u.pin_changes[15:0], n[15:0]);
    // Resume compares; a match with the level bit low
    rd16(tcc_pkg::ADDR_ALT_HIGH, a);
    b = a + 16'h0018;
    wr_reg(tcc_pkg::ADDR_COMPARE_HIGH, b[15:8]);
    wr_reg(tcc_pkg::ADDR_COMPARE_LOW, b[7:0]);
    repeat (120) @(posedge mclk_in);
    chk({15'h0000, cmp_pin}, 16'h0000);
    // Flag still set and not armed: the next match must still move the pin
    wr_reg(tcc_pkg::ADDR_TIMER_CTRL, 8'h03);
    b = b + 16'h0018;
    wr_reg(tcc_pkg::ADDR_COMPARE_HIGH, b[15:8]);
    wr_reg(tcc_pkg::ADDR_COMPARE_LOW, b[7:0]);
    repeat (120) @(posedge mclk_in);
    chk({15'h0000, cmp_pin}, 16'h0001);
    rd_reg(tcc_pkg::ADDR_TIMER_STATUS, d);
    rd_reg(tcc_pkg::ADDR_COMPARE_LOW, d);
    chk({8'h00, d}, {8'h00, b[7:0]});
    rd_reg(tcc_pkg::ADDR_TIMER_STATUS, d);
    chk({15'h0000, d[tcc_pkg::STAT_OCF_BIT]}, 16'h0000);
    // Second reset in mid-run
    wr_reg(tcc_pkg::ADDR_TIMER_CTRL, 8'hFF);
    rd16(tcc_pkg::ADDR_CAPTURE_HIGH, c);
    @(posedge mclk_in);
    reset_n_in <= 1'b0;
    repeat (20) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    rd_reg(tcc_pkg::ADDR_TIMER_CTRL, d);
    chk({8'h00, d}, 16'h0002);
    rd16(tcc_pkg::ADDR_CAPTURE_HIGH, a);
    chk(a, c);
    rd16(tcc_pkg::ADDR_COMPARE_HIGH, a);
    chk(a, b);
    rd16(tcc_pkg::ADDR_ALT_HIGH, a);
    chk(a, 16'hFFFC);
    conclude();
  end

  // Whole run is about 6,450 cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    n_fail++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    conclude();
  end
endmodule // test_timer_capture_compare_16bit
